// File: logic/adcc_params.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// Register indexes; byte address is four times the index
`define ADCC_IDX_CONTROL_A 5'h00
`define ADCC_IDX_CONTROL_B 5'h01
`define ADCC_IDX_CONTROL_C 5'h02
`define ADCC_IDX_CONTROL_D 5'h03
`define ADCC_IDX_INT_ENABLE 5'h04
`define ADCC_IDX_INT_FLAGS 5'h05
`define ADCC_IDX_STATUS 5'h06
`define ADCC_IDX_DEBUG 5'h07
`define ADCC_IDX_CONTROL_E 5'h08
`define ADCC_IDX_CONTROL_F 5'h09
`define ADCC_IDX_COMMAND 5'h0A
`define ADCC_IDX_GAIN 5'h0B
`define ADCC_IDX_MUX_POS 5'h0C
`define ADCC_IDX_MUX_NEG 5'h0D
`define ADCC_IDX_RESULT 5'h10
`define ADCC_IDX_SAMPLE 5'h14
`define ADCC_IDX_CAL_0 5'h18
`define ADCC_IDX_CAL_1 5'h19
`define ADCC_IDX_CAL_2 5'h1A
`define ADCC_IDX_WIN_LOW 5'h1C
`define ADCC_IDX_WIN_HIGH 5'h1E

// Control A fields
`define ADCC_BIT_ENABLE 0
`define ADCC_BIT_LOW_LATENCY 5
`define ADCC_BIT_STANDBY_RUN 7

// Control B divider select field
`define ADCC_DIV_SEL_MSB 3
`define ADCC_DIV_SEL_LSB 0

// Interrupt flag positions
`define ADCC_FLAG_RESULT_READY 0
`define ADCC_FLAG_SAMPLE_READY 1
`define ADCC_FLAG_RESULT_OVERWRITE 3
`define ADCC_FLAG_SAMPLE_OVERWRITE 4
`define ADCC_FLAG_TRIGGER_OVERRUN 5
`define ADCC_FLAG_MASK 6'h3F

// Status field
`define ADCC_BIT_BUSY 0

// Writable bits per byte register
`define ADCC_MASK_CONTROL_A 8'hA1
`define ADCC_MASK_CONTROL_B 8'h0F
`define ADCC_MASK_CONTROL_C 8'h07
`define ADCC_MASK_CONTROL_D 8'h0F
`define ADCC_MASK_INT_ENABLE 8'h3F
`define ADCC_MASK_DEBUG 8'h01
`define ADCC_MASK_CONTROL_F 8'h7F
`define ADCC_MASK_COMMAND 8'hF7
`define ADCC_MASK_GAIN 8'hF9
`define ADCC_MASK_FULL 8'hFF

// Reset values
`define ADCC_RESET_BYTE 8'h00
`define ADCC_RESET_HALF 16'h0000
`define ADCC_RESET_FLAGS 6'h00

// Sequencer timing in converter clock ticks
`define ADCC_WARMUP_TICKS 8'h04
`define ADCC_CONVERT_TICKS 8'h0D

// Bus responses
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// File: logic/adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_WARMUP,
    ADCC_CONVERT
  } adcc_state_t;
  typedef logic [4:0] adcc_index_t;
endpackage : adcc_pkg

// File: logic/adcc_clock_divider.sv
// Converter clock enable generator with selectable divide ratio
`timescale 1ns/1ps
`default_nettype none
module adcc_clock_divider #(
  parameter int CNT_W = 7
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [3:0] i_select,
  output logic o_tick
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] ratio;

  // ----------------------------------------
  // Ratio decode
  // ----------------------------------------
  always_comb begin
    if (!i_select[3]) begin
      ratio = CNT_W'({1'b0, i_select[2:0], 1'b0} + 5'h02); // R9
    end else if (!i_select[2]) begin
      ratio = CNT_W'(({4'h0, i_select[1:0]} << 2) + 6'h14); // R10
    end else begin
      ratio = CNT_W'(({5'h00, i_select[1:0]} << 3) + 7'h28); // R11
    end
  end

  // ----------------------------------------
  // Divide counter
  // ----------------------------------------
  // Stopped counter restarts at zero so the first tick has the full period
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count_r <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count_r <= '0;
      o_tick <= 1'b0;
    end else if (count_r >= ratio - CNT_W'(1)) begin
      count_r <= '0; // R12
      o_tick <= 1'b1; // R12
    end else begin
      count_r <= count_r + CNT_W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule // adcc_clock_divider
`default_nettype wire

// File: logic/adcc_control.sv
// Converter control registers, clock prescaler and conversion sequencer with AXI4-Lite slave
// Function
// [R1] Control A bit 0 enables the converter; zero keeps it off; resets zero.
// [R2] Standby run clear: no standby operation, but running conversion finishes first.
// [R3] Standby run set: operate in standby, request main clock when triggered.
// [R4] Low latency clear: power analog parts only when a conversion starts.
// [R5] Low latency set: keep selected analog parts powered continuously.
// [R6] Low latency never keeps the clock source alive; software must.
// [R7] Control A: standby run bit 7, low latency bit 5, enable bit 0.
// [R8] Control B bits 3:0 select converter clock division ratio.
// [R9] Codes 0x0..0x7 divide by 2,4,...,16.
// [R10] Codes 0x8..0xB divide by 20,24,28,32.
// [R11] Codes 0xC..0xF divide by 40,48,56,64.
// [R12] Converter clock is an enable pulse from a reloading divide counter.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_params.svh"
module adcc_control
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int MEM_DEPTH = 27,
  parameter logic [7:0] WARMUP_TICKS = `ADCC_WARMUP_TICKS,
  parameter logic [7:0] CONVERT_TICKS = `ADCC_CONVERT_TICKS
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_standby_sleep,
  input wire logic i_conversion_trigger,
  input wire logic [31:0] i_result_data,
  input wire logic [15:0] i_sample_data,
  output logic o_converter_enabled,
  output logic o_converter_clock_enable,
  output logic o_analog_power_on,
  output logic o_main_clock_request,
  output logic o_converter_busy,
  output logic o_conversion_done
);
  logic [7:0] mem_r [MEM_DEPTH];
  logic [15:0] win_low_r;
  logic [15:0] win_high_r;
  logic [5:0] flags_r;
  logic aw_held_r;
  logic w_held_r;
  adcc_index_t wr_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic ar_fire;
  adcc_index_t rd_idx;
  logic [31:0] rd_word;
  logic rd_ok;
  adcc_state_t state_r;
  logic [7:0] ticks_r;
  logic enable;
  logic low_latency;
  logic standby_run;
  logic operating;
  logic accept_trigger;
  logic conv_tick;
  logic done_pulse;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign enable = mem_r[`ADCC_IDX_CONTROL_A][`ADCC_BIT_ENABLE]; // R1 R7
  assign low_latency = mem_r[`ADCC_IDX_CONTROL_A][`ADCC_BIT_LOW_LATENCY]; // R7
  assign standby_run = mem_r[`ADCC_IDX_CONTROL_A][`ADCC_BIT_STANDBY_RUN]; // R7

  function automatic logic [7:0] byte_mask(input adcc_index_t idx);
    case (idx)
      `ADCC_IDX_CONTROL_A: byte_mask = `ADCC_MASK_CONTROL_A; // R7
      `ADCC_IDX_CONTROL_B: byte_mask = `ADCC_MASK_CONTROL_B; // R8
      `ADCC_IDX_CONTROL_C: byte_mask = `ADCC_MASK_CONTROL_C;
      `ADCC_IDX_CONTROL_D: byte_mask = `ADCC_MASK_CONTROL_D;
      `ADCC_IDX_INT_ENABLE: byte_mask = `ADCC_MASK_INT_ENABLE;
      `ADCC_IDX_DEBUG: byte_mask = `ADCC_MASK_DEBUG;
      `ADCC_IDX_CONTROL_E: byte_mask = `ADCC_MASK_FULL;
      `ADCC_IDX_CONTROL_F: byte_mask = `ADCC_MASK_CONTROL_F;
      `ADCC_IDX_COMMAND: byte_mask = `ADCC_MASK_COMMAND;
      `ADCC_IDX_GAIN: byte_mask = `ADCC_MASK_GAIN;
      `ADCC_IDX_MUX_POS: byte_mask = `ADCC_MASK_FULL;
      `ADCC_IDX_MUX_NEG: byte_mask = `ADCC_MASK_FULL;
      `ADCC_IDX_CAL_0: byte_mask = `ADCC_MASK_FULL;
      `ADCC_IDX_CAL_1: byte_mask = `ADCC_MASK_FULL;
      `ADCC_IDX_CAL_2: byte_mask = `ADCC_MASK_FULL;
      default: byte_mask = 8'h00;
    endcase
  endfunction

  function automatic logic is_mapped(input adcc_index_t idx);
    is_mapped = (byte_mask(idx) != 8'h00) || idx == `ADCC_IDX_INT_FLAGS || idx == `ADCC_IDX_STATUS
      || idx == `ADCC_IDX_RESULT || idx == `ADCC_IDX_SAMPLE || idx == `ADCC_IDX_WIN_LOW
      || idx == `ADCC_IDX_WIN_HIGH;
  endfunction

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data may arrive in either order; each is held until the response
  assign wr_fire = aw_held_r && w_held_r && !o_bvalid;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      aw_held_r <= 1'b0;
      o_awready <= 1'b1;
      wr_idx_r <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_r <= 1'b1;
      o_awready <= 1'b0;
      wr_idx_r <= i_awaddr[6:2];
    end else if (o_bvalid && i_bready) begin
      aw_held_r <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      w_held_r <= 1'b0;
      o_wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_r <= 1'b1;
      o_wready <= 1'b0;
      wdata_r <= i_wdata;
      wstrb_r <= i_wstrb;
    end else if (o_bvalid && i_bready) begin
      w_held_r <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_bvalid <= 1'b0;
      o_bresp <= `ADCC_RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= is_mapped(wr_idx_r) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Byte registers and thresholds
  // ----------------------------------------
  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < MEM_DEPTH; k++) begin
        mem_r[k] <= `ADCC_RESET_BYTE; // R1
      end
    end else if (wr_fire && wstrb_r[0] && byte_mask(wr_idx_r) != 8'h00) begin
      mem_r[wr_idx_r] <= wdata_r[7:0] & byte_mask(wr_idx_r); // R7 R8
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      win_low_r <= `ADCC_RESET_HALF;
      win_high_r <= `ADCC_RESET_HALF;
    end else if (wr_fire) begin
      if (wr_idx_r == `ADCC_IDX_WIN_LOW) begin
        if (wstrb_r[0]) win_low_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) win_low_r[15:8] <= wdata_r[15:8];
      end
      if (wr_idx_r == `ADCC_IDX_WIN_HIGH) begin
        if (wstrb_r[0]) win_high_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) win_high_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign ar_fire = i_arvalid && o_arready;
  assign rd_idx = i_araddr[6:2];

  always_comb begin
    rd_ok = is_mapped(rd_idx);
    rd_word = 32'h0000_0000;
    case (rd_idx)
      `ADCC_IDX_INT_FLAGS: rd_word = {26'h0, flags_r};
      `ADCC_IDX_STATUS: rd_word = {31'h0, state_r != ADCC_IDLE};
      `ADCC_IDX_RESULT: rd_word = i_result_data;
      `ADCC_IDX_SAMPLE: rd_word = {16'h0, i_sample_data};
      `ADCC_IDX_WIN_LOW: rd_word = {16'h0, win_low_r};
      `ADCC_IDX_WIN_HIGH: rd_word = {16'h0, win_high_r};
      default: rd_word = {24'h0, (rd_idx < adcc_index_t'(MEM_DEPTH)) ? mem_r[rd_idx] : 8'h00};
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `ADCC_RESP_OKAY;
    end else if (ar_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_ok ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  // Set wins over a same-cycle clear so no event is lost
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[`ADCC_FLAG_RESULT_READY] = done_pulse;
    flag_set[`ADCC_FLAG_SAMPLE_READY] = done_pulse;
    flag_set[`ADCC_FLAG_RESULT_OVERWRITE] = done_pulse && flags_r[`ADCC_FLAG_RESULT_READY];
    flag_set[`ADCC_FLAG_SAMPLE_OVERWRITE] = done_pulse && flags_r[`ADCC_FLAG_SAMPLE_READY];
    flag_set[`ADCC_FLAG_TRIGGER_OVERRUN] = i_conversion_trigger && enable && state_r != ADCC_IDLE;
    if (wr_fire && wstrb_r[0] && wr_idx_r == `ADCC_IDX_INT_FLAGS) begin
      flag_clr = wdata_r[5:0] & `ADCC_FLAG_MASK;
    end
    if (ar_fire && rd_idx == `ADCC_IDX_RESULT) begin
      flag_clr[`ADCC_FLAG_RESULT_READY] = 1'b1;
    end
    if (ar_fire && rd_idx == `ADCC_IDX_SAMPLE) begin
      flag_clr[`ADCC_FLAG_SAMPLE_READY] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      flags_r <= `ADCC_RESET_FLAGS;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------
  // Converter clock
  // ----------------------------------------
  // Without standby run the clock stops only once the sequencer is idle
  assign operating = enable && (!i_standby_sleep || standby_run || state_r != ADCC_IDLE); // R1 R2 R3

  adcc_clock_divider #(
    .CNT_W(7)
  ) u_divider (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_run(operating),
    .i_select(mem_r[`ADCC_IDX_CONTROL_B][`ADCC_DIV_SEL_MSB:`ADCC_DIV_SEL_LSB]), // R8
    .o_tick(conv_tick)
  );

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_converter_clock_enable <= 1'b0;
    end else begin
      o_converter_clock_enable <= conv_tick; // R12
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // Triggers in standby are refused unless standby run is set
  assign accept_trigger = i_conversion_trigger && enable && state_r == ADCC_IDLE
    && (!i_standby_sleep || standby_run); // R2 R3
  assign done_pulse = state_r == ADCC_CONVERT && conv_tick && ticks_r == 8'h01;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ADCC_IDLE;
      ticks_r <= '0;
    end else if (!enable) begin
      state_r <= ADCC_IDLE; // R1
      ticks_r <= '0;
    end else begin
      case (state_r)
        ADCC_IDLE: begin
          if (accept_trigger && !low_latency) begin
            state_r <= ADCC_WARMUP; // R4
            ticks_r <= WARMUP_TICKS;
          end else if (accept_trigger) begin
            state_r <= ADCC_CONVERT; // R5
            ticks_r <= CONVERT_TICKS;
          end
        end
        ADCC_WARMUP: begin
          if (conv_tick && ticks_r <= 8'h01) begin
            state_r <= ADCC_CONVERT;
            ticks_r <= CONVERT_TICKS;
          end else if (conv_tick) begin
            ticks_r <= ticks_r - 8'h01;
          end
        end
        ADCC_CONVERT: begin
          if (conv_tick && ticks_r <= 8'h01) begin
            state_r <= ADCC_IDLE; // R2
            ticks_r <= '0;
          end else if (conv_tick) begin
            ticks_r <= ticks_r - 8'h01;
          end
        end
        default: begin
          state_r <= ADCC_IDLE;
          ticks_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Power and clock requests
  // ----------------------------------------
  // Low latency powers only the analog parts; clock source stays software's job
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_analog_power_on <= 1'b0;
      o_main_clock_request <= 1'b0;
    end else begin
      o_analog_power_on <= operating && (low_latency || state_r != ADCC_IDLE); // R4 R5
      o_main_clock_request <= standby_run && i_standby_sleep && enable
        && (accept_trigger || state_r != ADCC_IDLE); // R3 R6
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_converter_enabled <= 1'b0;
      o_converter_busy <= 1'b0;
      o_conversion_done <= 1'b0;
    end else begin
      o_converter_enabled <= enable; // R1
      o_converter_busy <= state_r != ADCC_IDLE;
      o_conversion_done <= done_pulse;
    end
  end
endmodule // adcc_control
`default_nettype wire

// File: test/adcc_control_monitor.sv
// Port-level checks on the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_control_monitor (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_standby_sleep,
  input wire logic i_conversion_trigger,
  input wire logic o_converter_enabled,
  input wire logic o_converter_clock_enable,
  input wire logic o_analog_power_on,
  input wire logic o_main_clock_request,
  input wire logic o_converter_busy,
  input wire logic o_conversion_done
);
  default clocking mon_cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // ------
  // Steps
  // ------
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_start_ok;
    i_conversion_trigger && o_converter_enabled && !o_converter_busy && !i_standby_sleep;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] o_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_rd_taken |=> o_rvalid)
    else $error("read answer late");
  a_tick_single: assert property (o_converter_clock_enable |=> !o_converter_clock_enable)
    else $error("tick longer than one cycle");
  a_tick_off: assert property (!o_converter_enabled [*3] |-> !o_converter_clock_enable)
    else $error("tick while disabled");
  a_start_busy: assert property (s_start_ok |-> ##2 o_converter_busy)
    else $error("trigger not taken");
  a_done_pulse: assert property (o_conversion_done |=> !o_conversion_done)
    else $error("done longer than one cycle");
  a_clkreq_sleep: assert property (o_main_clock_request |-> $past(i_standby_sleep))
    else $error("clock request outside sleep");
  a_power_busy: assert property (o_converter_busy [*2] |-> o_analog_power_on)
    else $error("analog off during conversion");
  a_power_off: assert property (!o_converter_enabled [*2] |-> !o_analog_power_on)
    else $error("analog on while disabled");
endmodule // adcc_control_monitor
bind adcc_control adcc_control_monitor adcc_control_monitor_i (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_awvalid(i_awvalid),
  .o_awready(o_awready),
  .i_wvalid(i_wvalid),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .i_arvalid(i_arvalid),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .i_standby_sleep(i_standby_sleep),
  .i_conversion_trigger(i_conversion_trigger),
  .o_converter_enabled(o_converter_enabled),
  .o_converter_clock_enable(o_converter_clock_enable),
  .o_analog_power_on(o_analog_power_on),
  .o_main_clock_request(o_main_clock_request),
  .o_converter_busy(o_converter_busy),
  .o_conversion_done(o_conversion_done)
);
`default_nettype wire

// File: test/test_adc_control_and_clock_prescaler.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_and_clock_prescaler;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [6:0] i_awaddr = 7'h00;
  logic i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic [6:0] i_araddr = 7'h00;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic i_standby_sleep = 1'b0;
  logic i_conversion_trigger = 1'b0;
  logic [31:0] i_result_data = 32'h0;
  logic [15:0] i_sample_data = 16'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic o_converter_enabled, o_converter_clock_enable, o_analog_power_on;
  logic o_main_clock_request, o_converter_busy, o_conversion_done;
  logic [33:0] rnote;
  logic [33:0] exp_rd_q[$];
  logic [1:0] exp_b_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  // Short sequencer counts keep each conversion brief
  adcc_control #(.WARMUP_TICKS(8'h01), .CONVERT_TICKS(8'h02)) adcc_control_i (
    .i_clock(i_clock), .i_reset(i_reset),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_standby_sleep(i_standby_sleep), .i_conversion_trigger(i_conversion_trigger),
    .i_result_data(i_result_data), .i_sample_data(i_sample_data),
    .o_converter_enabled(o_converter_enabled), .o_converter_clock_enable(o_converter_clock_enable),
    .o_analog_power_on(o_analog_power_on), .o_main_clock_request(o_main_clock_request),
    .o_converter_busy(o_converter_busy), .o_conversion_done(o_conversion_done)
  );
  // ------
  // Scoring
  // ------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  // Ceiling well above the expected run length
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  always @(posedge i_clock) begin
    if (o_bvalid && i_bready && exp_b_q.size() > 0) begin
      check("bresp", {30'h0, exp_b_q.pop_front()}, {30'h0, o_bresp});
    end
    if (o_rvalid && i_rready && exp_rd_q.size() > 0) begin
      rnote = exp_rd_q.pop_front();
      check("rdata", rnote[31:0], o_rdata);
      check("rresp", {30'h0, rnote[33:32]}, {30'h0, o_rresp});
    end
  end
  // ------
  // Stimulus
  // ------
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_p;
    bit w_p;
    exp_b_q.push_back(er);
    aw_p = 1;
    w_p = 1;
    @(posedge i_clock);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge i_clock);
      if (aw_p && o_awready === 1'b1) begin
        aw_p = 0;
        i_awvalid <= 1'b0;
      end
      if (w_p && o_wready === 1'b1) begin
        w_p = 0;
        i_wvalid <= 1'b0;
      end
    end
    while (o_bvalid !== 1'b1) @(posedge i_clock);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_rd_q.push_back({er, d});
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clock); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clock); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
  endtask
  task automatic trig();
    @(posedge i_clock);
    i_conversion_trigger <= 1'b1;
    @(posedge i_clock);
    i_conversion_trigger <= 1'b0;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_conversion_done !== 1'b1);
  endtask
  function automatic int ratio(input int c);
    if (c < 8) return 2 * (c + 1);
    if (c < 12) return 20 + 4 * (c - 8);
    return 40 + 8 * (c - 12);
  endfunction
  initial begin
    int n;
    logic [31:0] r;
    void'($urandom(30));
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(7'h00, 32'h0, 2'h0);
    rd(7'h04, 32'h0, 2'h0);
    repeat (3) begin
      r = $urandom;
      wr(7'h00, r, 2'h0);
      rd(7'h00, r & 32'hA1, 2'h0);
      wr(7'h04, r, 2'h0);
      rd(7'h04, r & 32'h0F, 2'h0);
      wr(7'h70, r, 2'h0);
      rd(7'h70, r & 32'hFFFF, 2'h0);
    end
    wr(7'h38, r, 2'h2);
    rd(7'h38, 32'h0, 2'h2);
    wr(7'h00, 32'h01, 2'h0);
    repeat (3) @(posedge i_clock);
    check("enabled", 32'h1, {31'h0, o_converter_enabled});
    for (int c = 0; c < 16; c++) begin
      wr(7'h04, 32'(c), 2'h0);
      repeat (2) do @(posedge i_clock); while (o_converter_clock_enable !== 1'b1);
      n = 0;
      do begin
        @(posedge i_clock);
        n++;
      end while (o_converter_clock_enable !== 1'b1);
      check("divide ratio", 32'(ratio(c)), 32'(n));
    end
    wr(7'h04, 32'h07, 2'h0);
    check("analog idle", 32'h0, {31'h0, o_analog_power_on});
    trig();
    wait_done(n);
    check("warmup timing", 32'h1, {31'h0, n >= 32 && n <= 52});
    wr(7'h00, 32'h21, 2'h0);
    repeat (2) @(posedge i_clock);
    check("analog held", 32'h1, {31'h0, o_analog_power_on});
    trig();
    wait_done(n);
    check("fast timing", 32'h1, {31'h0, n >= 16 && n <= 36});
    wr(7'h00, 32'h01, 2'h0);
    wr(7'h14, 32'h3F, 2'h0);
    trig();
    repeat (3) @(posedge i_clock);
    check("busy", 32'h1, {31'h0, o_converter_busy});
    check("analog on demand", 32'h1, {31'h0, o_analog_power_on});
    trig();
    wait_done(n);
    rd(7'h14, 32'h23, 2'h0);
    @(posedge i_clock);
    i_result_data <= $urandom;
    i_sample_data <= 16'($urandom);
    @(posedge i_clock);
    rd(7'h40, i_result_data, 2'h0);
    rd(7'h50, {16'h0, i_sample_data}, 2'h0);
    rd(7'h14, 32'h20, 2'h0);
    wr(7'h00, 32'hA1, 2'h0);
    i_standby_sleep <= 1'b1;
    trig();
    repeat (2) @(posedge i_clock);
    check("clock request", 32'h1, {31'h0, o_main_clock_request});
    wait_done(n);
    repeat (3) @(posedge i_clock);
    check("request dropped", 32'h0, {31'h0, o_main_clock_request});
    wr(7'h00, 32'h01, 2'h0);
    trig();
    repeat (3) @(posedge i_clock);
    check("sleep refuses", 32'h0, {31'h0, o_converter_busy});
    i_standby_sleep <= 1'b0;
    trig();
    i_standby_sleep <= 1'b1;
    wait_done(n);
    check("finish in sleep", 32'h1, {31'h0, n <= 52});
    i_standby_sleep <= 1'b0;
    wr(7'h00, 32'h0, 2'h0);
    repeat (3) @(posedge i_clock);
    check("disabled", 32'h0, {31'h0, o_converter_enabled});
    n = 0;
    repeat (200) begin
      @(posedge i_clock);
      n = n + int'(o_converter_clock_enable === 1'b1);
    end
    check("ticks stopped", 32'h0, 32'(n));
    repeat (3) @(posedge i_clock);
    give_verdict();
  end
endmodule // test_adc_control_and_clock_prescaler
`default_nettype wire
